// >>> core/nv_map.svh
// Offsets, field positions, reset values and sizes for the EEPROM control.
// Assumes inclusion by nv_pkg and by the design modules; definitions only.
`ifndef NV_MAP_SVH
`define NV_MAP_SVH

// ****************************************************************
// Register indices (byte address is four times the index)
// ****************************************************************
`define NV_CTRL_IDX 8'h3B
`define NV_PROTECT_IDX 8'h35
`define NV_MAP_IDX 8'h3C
`define NV_SYS_IDX 8'h3D
`define NV_STATUS_IDX 8'h3E

// ****************************************************************
// Control register fields, then protect, system and status bits
// ****************************************************************
`define NV_B_ODD 7
`define NV_B_EVEN 6
`define NV_B_BYTE 4
`define NV_B_ROW 3
`define NV_B_ERASE 2
`define NV_B_LAT 1
`define NV_B_HV 0
`define NV_CTRL_WMASK 8'hDF
`define NV_B_BULK_ERASE_LOCK 7
`define NV_B_EN 0
`define NV_B_PCS 1
`define NV_B_REFUSED 2

// ****************************************************************
// Reset values and protect write mask
// ****************************************************************
`define NV_CTRL_RST 8'h00
`define NV_PROTECT_RST 8'hBF
`define NV_PROTECT_WMASK 8'hBF
`define NV_MAP_RST 4'h0
`define NV_SYS_RST 2'h1

// ****************************************************************
// Array geometry and pump dividers
// ****************************************************************
`define NV_SPACE_BIT 16
`define NV_ARRAY_LO 12'hD80
`define NV_TEST_LO 12'hD60
`define NV_USER_BYTES 10'd640
`define NV_TEST_BYTES 10'd32
`define NV_HALF_BYTES 10'd320
`define NV_BLK1_LO 10'd32
`define NV_BLK2_LO 10'd96
`define NV_BLK3_LO 10'd224
`define NV_BLK4_LO 10'd512
`define NV_BUS_PUMP_DIV 4
`define NV_OSC_PUMP_DIV 7

`endif

// >>> core/nv_pkg.sv
// Types and shared decode functions for the EEPROM control.
// Assumes nv_map.svh is on the include path.
`include "nv_map.svh"

package nv_pkg;

  // Operation selected by the control register
  typedef enum logic [1:0] {OP_PROGRAM, OP_BYTE_ERASE, OP_ROW_ERASE, OP_BULK_ERASE} op_e;

  // Protect block holding an array offset; 5 for test cells
  function automatic logic [2:0] block_of(input logic [9:0] off);
    if (off < `NV_BLK1_LO) block_of = 3'h0;
    else if (off < `NV_BLK2_LO) block_of = 3'h1;
    else if (off < `NV_BLK3_LO) block_of = 3'h2;
    else if (off < `NV_BLK4_LO) block_of = 3'h3;
    else if (off < `NV_USER_BYTES) block_of = 3'h4;
    else block_of = 3'h5;
  endfunction

  // Sixteen-byte row holding an array offset
  function automatic logic [5:0] row_of(input logic [9:0] off);
    row_of = off[9:4];
  endfunction

endpackage

// >>> core/nv_pump_tick.sv
// Charge pump clock enable: one-cycle pulses from a divider.
// Assumes a single clock; the oscillator source is a slower divider.
`timescale 1ns/1ps
`default_nettype none
`include "nv_map.svh"

module nv_pump_tick #(
  parameter int BUS_DIV = `NV_BUS_PUMP_DIV,
  parameter int OSC_DIV = `NV_OSC_PUMP_DIV
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic osc_select,
  output logic tick_q
);
  // Divider count
  logic [7:0] cnt_q;
  // Terminal count for the chosen source
  logic [7:0] last;

  assign last = osc_select ? 8'(OSC_DIV - 1) : 8'(BUS_DIV - 1);

  // Divider and pulse
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      cnt_q <= 8'h00;
      tick_q <= 1'b0;
    end else if (cnt_q >= last) begin
      cnt_q <= 8'h00;
      tick_q <= 1'b1;
    end else begin
      cnt_q <= cnt_q + 8'h01;
      tick_q <= 1'b0;
    end
  end
endmodule // nv_pump_tick

`default_nettype wire

// >>> core/nv_cell_array.sv
// EEPROM cell storage: user bytes plus test cells, program and erase.
// Assumes operations are already checked for protection by the caller.
`timescale 1ns/1ps
`default_nettype none
`include "nv_map.svh"

module nv_cell_array
  import nv_pkg::*;
#(
  parameter int DEPTH = 672
) (
  input wire logic ref_clk,
  input wire logic op_valid,
  input wire op_e op_kind,
  input wire logic [9:0] op_off,
  input wire logic [7:0] op_data,
  input wire logic odd_sel,
  input wire logic even_sel,
  input wire logic [9:0] rd_off,
  output logic [7:0] rd_data
);
  // Cell contents; not reset, as cells keep data
  logic [7:0] mem [DEPTH];

  // Whether cell i takes part in the operation
  function automatic logic cell_hit(input int i);
    logic [9:0] c;
    logic half_same;
    logic par_ok;
    c = 10'(i);
    half_same = (c < `NV_HALF_BYTES) == (op_off < `NV_HALF_BYTES);
    par_ok = (odd_sel && c[4]) || (even_sel && !c[4]);
    cell_hit = 1'b0;
    unique case (op_kind)
      OP_PROGRAM: begin
        if ((odd_sel || even_sel) && c < `NV_USER_BYTES)
          cell_hit = half_same && par_ok && c[3:0] == op_off[3:0];
        else
          cell_hit = c == op_off;
      end
      OP_BYTE_ERASE: cell_hit = c == op_off;
      OP_ROW_ERASE: cell_hit = row_of(c) == row_of(op_off);
      OP_BULK_ERASE: cell_hit = c < `NV_USER_BYTES;
    endcase
    return cell_hit;
  endfunction

  // Program clears bits only; erase sets bytes to all ones
  always_ff @(posedge ref_clk) begin
    if (op_valid) begin
      for (int i = 0; i < DEPTH; i++) begin
        if (cell_hit(i))
          mem[i] <= (op_kind == OP_PROGRAM) ? (mem[i] & op_data) : 8'hFF;
      end
    end
  end

  assign rd_data = (int'(rd_off) < DEPTH) ? mem[rd_off] : 8'hFF;
endmodule // nv_cell_array

`default_nettype wire

// >>> core/eeprom_program_erase_control.sv
// EEPROM program/erase control: array placement, control register,
// capture of address and data, erase scope, block protection, pump.
// Assumes an Avalon-MM master on ref_clk; special_mode is an async pin.
`timescale 1ns/1ps
`default_nettype none
`include "nv_map.svh"

module eeprom_program_erase_control
  import nv_pkg::*;
#(
  parameter int BUS_DIV = `NV_BUS_PUMP_DIV,
  parameter int OSC_DIV = `NV_OSC_PUMP_DIV
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [16:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic special_mode,
  output logic vpp_enable_q,
  output logic pump_osc_q
);
  // ****************************************************************
  // State
  // ****************************************************************
  logic [7:0] ctrl_q; // Program control register
  logic [7:0] protect_q; // Block protect register
  logic [3:0] map_q; // 4k region holding the array
  logic [1:0] sys_q; // Enable and pump clock select
  logic cap_valid_q; // Address and data captured
  logic [9:0] cap_off_q; // Captured array offset
  logic [7:0] cap_data_q; // Captured data
  logic refused_q; // Sticky: an operation was refused
  logic special_s1_q; // Synchroniser first stage
  logic special_q; // Synchronised special mode
  logic wait_q; // Avalon waitrequest
  logic [31:0] rdata_q; // Avalon read data
  logic pump_tick; // Pump clock enable pulse

  // ****************************************************************
  // Decode
  // ****************************************************************
  logic req; // A request is presented
  logic commit; // Edge at which the request completes
  logic wr_commit; // Write takes effect now
  logic reg_ok; // Register space, aligned
  logic [7:0] reg_idx; // Register index
  logic in_region; // Array window selected and enabled
  logic user_hit; // User cells addressed
  logic test_hit; // Test cells addressed
  logic arr_hit; // Any cell addressed
  logic [9:0] arr_off; // Cell offset
  logic [7:0] arr_rd; // Cell read data
  logic [7:0] rd_val; // Read value of the addressed item
  op_e op_kind; // Operation chosen by control bits
  logic refuse; // Operation blocked by protection
  logic op_try; // Operation conditions met but for protection
  logic op_fire; // Operation applied this cycle
  logic same_loc; // Write hits the captured location

  assign req = avs_read || avs_write;
  assign commit = req && !wait_q;
  assign wr_commit = avs_write && commit && avs_byteenable[0];
  assign reg_idx = avs_address[9:2];
  assign reg_ok = !avs_address[`NV_SPACE_BIT] && avs_address[1:0] == 2'b00
                  && avs_address[15:10] == 6'h00;

  // Window decode: region and enable gate every cell access
  assign in_region = avs_address[`NV_SPACE_BIT] && avs_address[15:12] == map_q
                     && sys_q[`NV_B_EN];
  assign user_hit = in_region && avs_address[11:0] >= `NV_ARRAY_LO;
  assign test_hit = in_region && special_q && avs_address[11:0] >= `NV_TEST_LO
                    && avs_address[11:0] < `NV_ARRAY_LO;
  assign arr_hit = user_hit || test_hit;

  // Cell offset: user cells first, test cells after them
  always_comb begin
    if (test_hit)
      arr_off = `NV_USER_BYTES + 10'(avs_address[11:0] - `NV_TEST_LO);
    else
      arr_off = 10'(avs_address[11:0] - `NV_ARRAY_LO);
  end

  // Operation kind from erase and mode bits
  always_comb begin
    if (!ctrl_q[`NV_B_ERASE])
      op_kind = OP_PROGRAM;
    else if (ctrl_q[`NV_B_BYTE])
      op_kind = OP_BYTE_ERASE;
    else if (ctrl_q[`NV_B_ROW])
      op_kind = OP_ROW_ERASE;
    else
      op_kind = OP_BULK_ERASE;
  end

  // Protection check against the captured location
  always_comb begin
    logic [2:0] blk;
    blk = block_of(cap_off_q);
    refuse = 1'b0;
    unique case (op_kind)
      OP_PROGRAM, OP_BYTE_ERASE: begin
        refuse = (blk < 3'h5) && protect_q[blk];
      end
      OP_ROW_ERASE: begin
        refuse = protect_q[`NV_B_BULK_ERASE_LOCK] || ((blk < 3'h5) && protect_q[blk]);
      end
      OP_BULK_ERASE: begin
        refuse = protect_q[`NV_B_BULK_ERASE_LOCK] || (|protect_q[4:0]);
      end
    endcase
  end

  // Voltage on, address latched: apply on each pump tick, no timeout
  assign op_try = ctrl_q[`NV_B_HV] && ctrl_q[`NV_B_LAT] && cap_valid_q;
  assign op_fire = op_try && pump_tick && !refuse;
  assign same_loc = cap_off_q == arr_off;

  // Read mux; latched array reads return zero
  always_comb begin
    rd_val = 8'h00;
    if (arr_hit) begin
      if (!ctrl_q[`NV_B_LAT])
        rd_val = arr_rd;
    end else if (reg_ok) begin
      unique case (reg_idx)
        `NV_CTRL_IDX: rd_val = ctrl_q;
        `NV_PROTECT_IDX: rd_val = protect_q;
        `NV_MAP_IDX: rd_val = {4'h0, map_q};
        `NV_SYS_IDX: rd_val = {6'h00, sys_q};
        `NV_STATUS_IDX: rd_val = {5'h00, refused_q, vpp_enable_q, cap_valid_q};
        default: rd_val = 8'h00;
      endcase
    end
  end

  // ****************************************************************
  // Avalon slave
  // ****************************************************************
  // One wait cycle: data loaded, then waitrequest low for one edge
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      wait_q <= 1'b1;
      rdata_q <= 32'h0000_0000;
    end else if (req && wait_q) begin
      wait_q <= 1'b0;
      rdata_q <= {24'h00_0000, rd_val};
    end else begin
      wait_q <= 1'b1;
    end
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  // Control register; bit 5 never stored
  always_ff @(posedge ref_clk) begin
    if (!rst_n)
      ctrl_q <= `NV_CTRL_RST;
    else if (wr_commit && reg_ok && reg_idx == `NV_CTRL_IDX)
      ctrl_q <= avs_writedata[7:0] & `NV_CTRL_WMASK;
  end

  // Protect, map and system registers
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      protect_q <= `NV_PROTECT_RST;
      map_q <= `NV_MAP_RST;
      sys_q <= `NV_SYS_RST;
    end else if (wr_commit && reg_ok) begin
      if (reg_idx == `NV_PROTECT_IDX)
        protect_q <= avs_writedata[7:0] & `NV_PROTECT_WMASK;
      if (reg_idx == `NV_MAP_IDX)
        map_q <= avs_writedata[3:0];
      if (reg_idx == `NV_SYS_IDX)
        sys_q <= avs_writedata[1:0];
    end
  end

  // Capture of address and data for an operation
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      cap_valid_q <= 1'b0;
      cap_off_q <= 10'h000;
      cap_data_q <= 8'h00;
    end else if (!ctrl_q[`NV_B_LAT]) begin
      cap_valid_q <= 1'b0;
    end else if (wr_commit && arr_hit && !ctrl_q[`NV_B_HV]) begin
      if (!cap_valid_q || same_loc) begin
        cap_valid_q <= 1'b1;
        cap_off_q <= arr_off;
        cap_data_q <= avs_writedata[7:0];
      end
    end
  end

  // Sticky refusal flag; a new refusal wins over the clear
  always_ff @(posedge ref_clk) begin
    if (!rst_n)
      refused_q <= 1'b0;
    else if (op_try && refuse)
      refused_q <= 1'b1;
    else if (wr_commit && reg_ok && reg_idx == `NV_STATUS_IDX
             && avs_writedata[`NV_B_REFUSED])
      refused_q <= 1'b0;
  end

  // Pump outputs and special mode synchroniser
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      vpp_enable_q <= 1'b0;
      pump_osc_q <= 1'b0;
      special_s1_q <= 1'b0;
      special_q <= 1'b0;
    end else begin
      vpp_enable_q <= ctrl_q[`NV_B_HV];
      pump_osc_q <= sys_q[`NV_B_PCS];
      special_s1_q <= special_mode;
      special_q <= special_s1_q;
    end
  end

  assign avs_readdata = rdata_q;
  assign avs_waitrequest = wait_q;

  // ****************************************************************
  // Submodules
  // ****************************************************************
  // Pump clock enable from bus divider or oscillator divider
  nv_pump_tick #(
    .BUS_DIV(BUS_DIV),
    .OSC_DIV(OSC_DIV)
  ) u_tick (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .osc_select(pump_osc_q),
    .tick_q(pump_tick)
  );

  // Cell storage with odd/even test programming
  nv_cell_array u_cells (
    .ref_clk(ref_clk),
    .op_valid(op_fire),
    .op_kind(op_kind),
    .op_off(cap_off_q),
    .op_data(cap_data_q),
    .odd_sel(ctrl_q[`NV_B_ODD]),
    .even_sel(ctrl_q[`NV_B_EVEN]),
    .rd_off(arr_off),
    .rd_data(arr_rd)
  );

  // ****************************************************************
  // Assertions
  // ****************************************************************
  map_reset_a: assert property (@(posedge ref_clk) !rst_n |=> map_q == 4'h0)
    else $error("array not at reset region");

  map_write_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    wr_commit && reg_ok && reg_idx == `NV_MAP_IDX |=> map_q == $past(avs_writedata[3:0]))
    else $error("map write not taken");

  enable_gate_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    avs_read && wait_q && avs_address[`NV_SPACE_BIT] && !sys_q[`NV_B_EN]
    |=> avs_readdata == 32'h0000_0000)
    else $error("disabled array answered");

  ctrl_bit5_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !ctrl_q[5])
    else $error("control bit 5 set");

  hv_ignore_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    wr_commit && arr_hit && ctrl_q[`NV_B_HV] && ctrl_q[`NV_B_LAT]
    |=> $stable(cap_data_q) && $stable(cap_off_q))
    else $error("array write taken under high voltage");

  other_loc_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    wr_commit && arr_hit && cap_valid_q && !same_loc && ctrl_q[`NV_B_LAT]
    |=> cap_off_q == $past(cap_off_q))
    else $error("other location captured during operation");

  refuse_flag_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    op_try && refuse |=> refused_q)
    else $error("refusal not flagged");

  bulk_lock_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    op_fire |-> !(protect_q[`NV_B_BULK_ERASE_LOCK] && op_kind inside {OP_ROW_ERASE, OP_BULK_ERASE}))
    else $error("erase under bulk lock");

  byte_scope_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    ctrl_q[`NV_B_ERASE] && ctrl_q[`NV_B_BYTE] |-> op_kind == OP_BYTE_ERASE)
    else $error("byte bit did not select byte erase");

  vpp_follow_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    wr_commit && reg_ok && reg_idx == `NV_CTRL_IDX && avs_writedata[0] |-> ##2 vpp_enable_q)
    else $error("voltage not switched on");

  pump_select_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    wr_commit && reg_ok && reg_idx == `NV_SYS_IDX |-> ##2 pump_osc_q == $past(avs_writedata[1], 2))
    else $error("pump clock source not selected");

  // Voltage output follows the bit for as long as it stays set
  vpp_hold_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    ctrl_q[`NV_B_HV] |=> vpp_enable_q)
    else $error("voltage dropped while bit set");

  // Unlatched user reads return the cell whatever the protection
  read_pass_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    avs_read && wait_q && user_hit && !ctrl_q[`NV_B_LAT]
    |=> avs_readdata[7:0] == $past(arr_rd))
    else $error("array read altered");

  // Clearing the latch drops any captured location
  latch_clear_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !ctrl_q[`NV_B_LAT] |=> !cap_valid_q)
    else $error("capture kept after latch cleared");
endmodule // eeprom_program_erase_control

`default_nettype wire

// >>> sim/cpu_bus_model.sv
// CPU core model: Avalon-MM bus cycles and program/erase sequences.
// Assumes one or more wait cycles per access and nv_map.svh offsets.
`timescale 1ns/1ps
`default_nettype none
`include "nv_map.svh"

module cpu_bus_model (
  input wire logic ref_clk,
  input wire logic avs_waitrequest,
  output var logic [16:0] avs_address,
  output var logic avs_read,
  output var logic avs_write,
  output var logic [31:0] avs_writedata,
  output var logic [3:0] avs_byteenable
);
  // ********
  // Bus cycles
  // ********
  // Idle bus at time zero
  initial begin
    avs_address = 17'h00000;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h00000000;
    avs_byteenable = 4'h0;
  end

  // One access, held until waitrequest is sampled low
  task automatic cycle(input logic rd, input logic [16:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    avs_address <= a;
    avs_read <= rd;
    avs_write <= !rd;
    avs_writedata <= {24'h000000, d};
    avs_byteenable <= 4'hF;
    @(posedge ref_clk iff !avs_waitrequest);
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask

  // Register write by index
  task automatic reg_wr(input logic [7:0] idx, input logic [7:0] d);
    cycle(1'b0, {1'b0, 6'h00, idx, 2'b00}, d);
  endtask

  // Array write by CPU address
  task automatic arr_wr(input logic [15:0] a, input logic [7:0] d);
    cycle(1'b0, {1'b1, a}, d);
  endtask

  // ********
  // Program/erase sequence
  // ********
  // Arm, write target, add voltage, hold, then clear control
  task automatic op(input logic [7:0] c, input logic [15:0] a, input logic [7:0] d);
    reg_wr(`NV_CTRL_IDX, c);
    arr_wr(a, d);
    reg_wr(`NV_CTRL_IDX, c | 8'h01);
    repeat (12) @(posedge ref_clk);
    reg_wr(`NV_CTRL_IDX, 8'h00);
  endtask
endmodule // cpu_bus_model
`default_nettype wire

// >>> sim/eeprom_program_erase_control_tb.sv
// Self-checking bench for the EEPROM program/erase control.
// Assumes cpu_bus_model drives the bus; reads are checked from a queue.
`timescale 1ns/1ps
`default_nettype none
`include "nv_map.svh"

module eeprom_program_erase_control_tb;
  import nv_pkg::*;
  logic ref_clk = 1'b0; // Bus clock
  logic rst_n = 1'b0; // Reset, active low
  logic special_mode = 1'b0; // Test cell access pin
  logic [16:0] avs_address;
  logic avs_read;
  logic avs_write;
  logic [31:0] avs_writedata;
  logic [3:0] avs_byteenable;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic vpp_enable_q;
  logic pump_osc_q;
  logic [31:0] exp_q[$]; // Expected read data, oldest first
  int fails = 0;
  int num_checks = 0;
  logic [15:0] lfsr_q = 16'hEC14; // Seed 60436
  logic [7:0] rnd; // Random data byte

  // Clock at 250 MHz
  always #2 ref_clk = ~ref_clk;

  eeprom_program_erase_control #(.BUS_DIV(2), .OSC_DIV(3)) i_dut (
    .ref_clk(ref_clk), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .special_mode(special_mode), .vpp_enable_q(vpp_enable_q), .pump_osc_q(pump_osc_q));

  cpu_bus_model i_cpu (
    .ref_clk(ref_clk), .avs_waitrequest(avs_waitrequest), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable));

  // ********
  // Helpers
  // ********
  // One step of the shift register
  function automatic logic [15:0] lfsr_step(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  // Next random byte from the shift register
  task automatic next_rnd();
    lfsr_q = lfsr_step(lfsr_q);
    rnd = lfsr_q[7:0];
  endtask

  // Compare and count
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Register read with expected byte noted
  task automatic rd_reg(input logic [7:0] idx, input logic [7:0] exp);
    exp_q.push_back({24'h000000, exp});
    i_cpu.cycle(1'b1, {1'b0, 6'h00, idx, 2'b00}, 8'h00);
  endtask

  // Array read with expected byte noted
  task automatic rd_arr(input logic [15:0] a, input logic [7:0] exp);
    exp_q.push_back({24'h000000, exp});
    i_cpu.cycle(1'b1, {1'b1, a}, 8'h00);
  endtask

  // End of one test
  task automatic done(input string t);
    $display("test %s done, mismatches %0d", t, fails);
  endtask

  // Verdict and end of run
  task automatic final_report();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // Read data watcher: oldest note against each completed read
  always @(posedge ref_clk) begin
    if (avs_read && !avs_waitrequest) begin
      if (exp_q.size() == 0) chk("read queue", 32'h1, 32'h0);
      else chk("readdata", avs_readdata, exp_q.pop_front());
    end
  end

  // Watchdog for a hung handshake
  initial begin
    repeat (20000) @(posedge ref_clk);
    fails++;
    final_report();
  end

  // ********
  // Tests
  // ********
  initial begin
    repeat (16) @(posedge ref_clk);
    rst_n <= 1'b1;
    rd_reg(`NV_CTRL_IDX, 8'h00);
    rd_reg(`NV_PROTECT_IDX, 8'hBF);
    i_cpu.reg_wr(`NV_CTRL_IDX, 8'hFE);
    rd_reg(`NV_CTRL_IDX, 8'hDE);
    i_cpu.reg_wr(`NV_CTRL_IDX, 8'h00);
    i_cpu.reg_wr(`NV_PROTECT_IDX, 8'h00);
    i_cpu.op(8'h06, 16'h0D80, 8'h00);
    rd_arr(16'h0D80, 8'hFF);
    rd_arr(16'h0FFF, 8'hFF);
    done("reset and bulk erase");
    // Program with mode bits set; stray writes must not land
    next_rnd();
    i_cpu.reg_wr(`NV_CTRL_IDX, 8'h1A);
    i_cpu.arr_wr(16'h0D85, rnd);
    i_cpu.arr_wr(16'h0D86, 8'h00);
    rd_arr(16'h0D85, 8'h00);
    i_cpu.reg_wr(`NV_CTRL_IDX, 8'h1B);
    i_cpu.arr_wr(16'h0D85, 8'h00);
    repeat (12) @(posedge ref_clk);
    chk("vpp_enable_q", {31'h0, vpp_enable_q}, 32'h1);
    i_cpu.reg_wr(`NV_CTRL_IDX, 8'h00);
    repeat (2) @(posedge ref_clk);
    chk("vpp_enable_q", {31'h0, vpp_enable_q}, 32'h0);
    rd_arr(16'h0D85, rnd);
    rd_arr(16'h0D86, 8'hFF);
    rd_arr(16'h0D84, 8'hFF);
    done("program");
    // Row erase then byte erase with row bit also set
    i_cpu.op(8'h02, 16'h0D94, 8'h11);
    i_cpu.op(8'h02, 16'h0D95, 8'h3C);
    i_cpu.op(8'h0E, 16'h0D8A, 8'h00);
    rd_arr(16'h0D85, 8'hFF);
    rd_arr(16'h0D94, 8'h11);
    i_cpu.op(8'h1E, 16'h0D95, 8'h00);
    rd_arr(16'h0D95, 8'hFF);
    rd_arr(16'h0D94, 8'h11);
    done("erase scope");
    // Protection at block 0/1 boundary, then bulk lock
    i_cpu.reg_wr(`NV_PROTECT_IDX, 8'h01);
    i_cpu.op(8'h02, 16'h0D9F, 8'h00);
    rd_arr(16'h0D9F, 8'hFF);
    rd_reg(`NV_STATUS_IDX, 8'h04);
    i_cpu.op(8'h02, 16'h0DA0, 8'h00);
    rd_arr(16'h0DA0, 8'h00);
    i_cpu.reg_wr(`NV_PROTECT_IDX, 8'h80);
    i_cpu.op(8'h0E, 16'h0DA0, 8'h00);
    rd_arr(16'h0DA0, 8'h00);
    i_cpu.reg_wr(`NV_STATUS_IDX, 8'h04);
    i_cpu.reg_wr(`NV_PROTECT_IDX, 8'h00);
    done("protection");
    // Enable, relocation and pump source
    i_cpu.reg_wr(`NV_SYS_IDX, 8'h00);
    rd_arr(16'h0D94, 8'h00);
    i_cpu.reg_wr(`NV_SYS_IDX, 8'h01);
    i_cpu.reg_wr(`NV_MAP_IDX, 8'h03);
    rd_arr(16'h3D94, 8'h11);
    rd_arr(16'h0D94, 8'h00);
    i_cpu.reg_wr(`NV_MAP_IDX, 8'h00);
    i_cpu.reg_wr(`NV_SYS_IDX, 8'h03);
    repeat (3) @(posedge ref_clk);
    chk("pump_osc_q", {31'h0, pump_osc_q}, 32'h1);
    i_cpu.op(8'h02, 16'h0D85, 8'h5A);
    rd_arr(16'h0D85, 8'h5A);
    i_cpu.reg_wr(`NV_SYS_IDX, 8'h01);
    repeat (3) @(posedge ref_clk);
    chk("pump_osc_q", {31'h0, pump_osc_q}, 32'h0);
    done("map and pump");
    // Test cells only in special mode
    rd_arr(16'h0D60, 8'h00);
    special_mode <= 1'b1;
    repeat (4) @(posedge ref_clk);
    next_rnd();
    i_cpu.op(8'h16, 16'h0D60, 8'h00);
    i_cpu.op(8'h02, 16'h0D60, rnd);
    rd_arr(16'h0D60, rnd);
    special_mode <= 1'b0;
    repeat (4) @(posedge ref_clk);
    rd_arr(16'h0D60, 8'h00);
    done("special mode");
    // Odd and even rows of the lower half in one cycle
    i_cpu.op(8'h06, 16'h0E00, 8'h00);
    next_rnd();
    i_cpu.op(8'hC2, 16'h0D83, rnd);
    rd_arr(16'h0D83, rnd);
    rd_arr(16'h0D93, rnd);
    rd_arr(16'h0EB3, rnd);
    rd_arr(16'h0EC3, 8'hFF);
    // Odd rows alone: target in an even row stays erased
    i_cpu.op(8'h82, 16'h0D84, 8'h0F);
    rd_arr(16'h0D94, 8'h0F);
    rd_arr(16'h0D84, 8'hFF);
    done("odd even");
    @(posedge ref_clk);
    final_report();
  end
endmodule // eeprom_program_erase_control_tb
`default_nettype wire
